// ---- fsr_pkg.sv ----
// Constants shared by the fan speed regulator core
package fsr_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int GLITCH_MIN_US = 500;
   localparam int GLITCH_CYCLES = (GLITCH_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC_FREQ_KHZ = 254;
   localparam int OSC_PERIOD_NS = 1000000 / OSC_FREQ_KHZ;
   localparam int OSC_HALF_CYCLES = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [6:0] OSC_HALF_LAST = 7'(OSC_HALF_CYCLES - 1);
   // ------------------------------------------------------------
   // Loop arithmetic
   // ------------------------------------------------------------
   localparam int TACH_COUNT = 4;
   localparam int TARGET_SHIFT = 7;
   localparam logic [15:0] PERIOD_MAX = 16'hffff;
   localparam logic [7:0] DAC_MAX = 8'hff;
   localparam logic [7:0] DAC_MIN = 8'h00;
   localparam logic [7:0] DAC_RESET = 8'h00;
   localparam logic [6:0] SLOW_STEP_MASK = 7'h7f;
   // ------------------------------------------------------------
   // Address strap
   // ------------------------------------------------------------
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_VCC = 2'h1;
   localparam logic [1:0] STRAP_OPEN = 2'h2;
   localparam logic [1:0] STRAP_RES = 2'h3;
   localparam logic [6:0] ADDR_GND = 7'h48;
   localparam logic [6:0] ADDR_VCC = 7'h4b;
   localparam logic [6:0] ADDR_OPEN = 7'h1b;
   localparam logic [6:0] ADDR_RES = 7'h1f;
   // ------------------------------------------------------------
   // Line modes
   // ------------------------------------------------------------
   localparam logic IO0_MODE_GPIO = 1'h0;
   localparam logic IO0_MODE_ALERT = 1'h1;
   localparam logic [1:0] IO1_MODE_OUT = 2'h0;
   localparam logic [1:0] IO1_MODE_GPI = 2'h1;
   localparam logic [1:0] IO1_MODE_FULL = 2'h2;
   localparam logic [1:0] IO2_MODE_GPIO = 2'h0;
   localparam logic [1:0] IO2_MODE_CLKOUT = 2'h1;
   localparam logic [1:0] IO2_MODE_CLKIN = 2'h2;
endpackage : fsr_pkg

// ---- fsr_glitch_filter.sv ----
// Glitch rejection filter for one tachometer input
`timescale 1ns/1ps
`default_nettype none
module fsr_glitch_filter #(
   parameter int MIN_CYCLES = 10000
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_raw,
   output logic o_clean
);
   logic [15:0] cnt_q, cnt_d;
   logic level_q, level_d;

   // ------------------------------------------------------------
   // Accept a new level only after it held long enough
   // ------------------------------------------------------------
   always_comb begin
      cnt_d = 16'h0000;
      level_d = level_q;
      if (i_raw != level_q) begin
         if (cnt_q >= 16'(MIN_CYCLES - 1)) begin
            level_d = i_raw;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cnt_q <= 16'h0000;
         level_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   assign o_clean = level_q;
endmodule : fsr_glitch_filter
`default_nettype wire

// ---- fsr_core.sv ----
// Fan speed regulator core: speed loop, tach monitors, lines, address strap
// Contract
// - Strap condition selects one of four addresses
// - Only the loop tach closes the loop
// - Other tachs are measured for monitoring only
// - Line 1 is output, input or full-speed override
// - Line 0 is open-drain I/O or alert
// - Line 2 is I/O, clock out or clock in
// - Loop drives tach frequency toward reference
// - Tach too fast increments DAC code
// - State is byte-wide or narrower except the 16-bit tach periods, reached over serial bus
// - Two tach pulses count one revolution
// - Target is (speed+1)*128 ticks shifted right by prescale
`timescale 1ns/1ps
`default_nettype none
module fsr_core
   import fsr_pkg::*;
#(
   parameter int GLITCH_LEN = GLITCH_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [1:0] i_addr_strap,
   input wire logic [7:0] i_speed_target_value,
   input wire logic [2:0] i_prescale_factor,
   input wire logic i_loop_tach_input,
   input wire logic i_monitor_tach_input_a,
   input wire logic i_monitor_tach_input_b,
   input wire logic i_monitor_tach_input_c,
   input wire logic i_fault,
   input wire logic i_io0_mode,
   input wire logic i_io0_level,
   input wire logic i_io_line_alert_capable,
   input wire logic [1:0] i_io1_mode,
   input wire logic i_io1_level,
   input wire logic i_io_line_override_capable,
   input wire logic [1:0] i_io2_mode,
   input wire logic i_io2_level,
   input wire logic i_io_line_clock_sync,
   output logic [6:0] o_slave_addr,
   output logic [7:0] o_feedback_sense_code,
   output logic [15:0] o_loop_period,
   output logic [15:0] o_monitor_period_a,
   output logic [15:0] o_monitor_period_b,
   output logic [15:0] o_monitor_period_c,
   output logic [7:0] o_rev_count,
   output logic o_full_speed,
   output logic o_tach_stall,
   output logic o_io0_in,
   output logic o_io1_in,
   output logic o_io2_in,
   output logic o_io_line_alert_capable,
   output logic o_io_line_alert_capable_oe_n,
   output logic o_io_line_override_capable,
   output logic o_io_line_override_capable_oe_n,
   output logic o_io_line_clock_sync,
   output logic o_io_line_clock_sync_oe_n
);
   logic [TACH_COUNT-1:0] tach_raw, tach_clean, tach_rise;
   logic [TACH_COUNT-1:0] tach_prev_q, tach_prev_d;
   logic [15:0] cnt_q [TACH_COUNT];
   logic [15:0] cnt_d [TACH_COUNT];
   logic [15:0] per_q [TACH_COUNT];
   logic [15:0] per_d [TACH_COUNT];
   logic [15:0] target;
   logic [6:0] div_q, div_d;
   logic phase_q, phase_d;
   logic ext_prev_q, ext_prev_d;
   logic osc_tick;
   logic [7:0] dac_q, dac_d;
   logic par_q, par_d;
   logic [7:0] rev_q, rev_d;
   logic cap_done_q, cap_done_d;
   logic [6:0] addr_q, addr_d;
   logic io0_oe_n_q, io0_oe_n_d;
   logic io1_oe_n_q, io1_oe_n_d;
   logic io2_oe_n_q, io2_oe_n_d;
   logic in0_q, in1_q, in2_q;
   logic override_q, override_d;
   logic stall;

   // ------------------------------------------------------------
   // Tachometer filtering and period measurement
   // ------------------------------------------------------------
   assign tach_raw = {i_monitor_tach_input_c, i_monitor_tach_input_b,
                      i_monitor_tach_input_a, i_loop_tach_input};

   genvar g;
   generate
      for (g = 0; g < TACH_COUNT; g++) begin : g_tach
         fsr_glitch_filter #(
            .MIN_CYCLES(GLITCH_LEN)
         ) u_filt (
            .i_clk_sys(i_clk_sys),
            .i_reset(i_reset),
            .i_raw(tach_raw[g]),
            .o_clean(tach_clean[g])
         );
         assign tach_rise[g] = tach_clean[g] & ~tach_prev_q[g];
         always_comb begin
            cnt_d[g] = cnt_q[g];
            per_d[g] = per_q[g];
            if (tach_rise[g]) begin
               per_d[g] = cnt_q[g];
               cnt_d[g] = 16'h0000;
            end else if (osc_tick && cnt_q[g] != PERIOD_MAX) begin
               cnt_d[g] = cnt_q[g] + 16'h0001;
            end
         end
         always_ff @(posedge i_clk_sys) begin
            if (i_reset) begin
               cnt_q[g] <= 16'h0000;
               per_q[g] <= 16'h0000;
            end else begin
               cnt_q[g] <= cnt_d[g];
               per_q[g] <= per_d[g];
            end
         end
      end
   endgenerate

   assign tach_prev_d = tach_clean;

   // ------------------------------------------------------------
   // Oscillator tick: internal divider or external clock
   // ------------------------------------------------------------
   always_comb begin
      div_d = div_q + 7'h01;
      phase_d = phase_q;
      if (div_q == OSC_HALF_LAST) begin
         div_d = 7'h00;
         phase_d = ~phase_q;
      end
      ext_prev_d = i_io_line_clock_sync;
   end

   assign osc_tick = (i_io2_mode == IO2_MODE_CLKIN)
                     ? (i_io_line_clock_sync & ~ext_prev_q)
                     : (div_q == OSC_HALF_LAST && !phase_q);

   // ------------------------------------------------------------
   // Speed loop on the loop tachometer only
   // ------------------------------------------------------------
   assign target = 16'(({8'h00, i_speed_target_value} + 16'h0001) << TARGET_SHIFT)
                   >> i_prescale_factor;
   assign stall = (cnt_q[0] == PERIOD_MAX);

   always_comb begin
      dac_d = dac_q;
      par_d = par_q;
      rev_d = rev_q;
      override_d = (i_io1_mode == IO1_MODE_FULL) && !i_io_line_override_capable;
      if (override_q) begin
         dac_d = DAC_MIN;
      end else if (tach_rise[0]) begin
         if (cnt_q[0] < target && dac_q != DAC_MAX) begin
            dac_d = dac_q + 8'h01;
         end else if (cnt_q[0] > target && dac_q != DAC_MIN) begin
            dac_d = dac_q - 8'h01;
         end
      end else if (osc_tick && cnt_q[0] > target
                   && (cnt_q[0][6:0] & SLOW_STEP_MASK) == 7'h00
                   && dac_q != DAC_MIN) begin
         dac_d = dac_q - 8'h01;
      end
      if (tach_rise[0]) begin
         par_d = ~par_q;
         if (par_q) begin
            rev_d = rev_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Address strap capture after reset release
   // ------------------------------------------------------------
   always_comb begin
      cap_done_d = 1'b1;
      addr_d = addr_q;
      if (!cap_done_q) begin
         unique case (i_addr_strap)
            STRAP_GND: addr_d = ADDR_GND;
            STRAP_VCC: addr_d = ADDR_VCC;
            STRAP_OPEN: addr_d = ADDR_OPEN;
            STRAP_RES: addr_d = ADDR_RES;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Open-drain lines
   // ------------------------------------------------------------
   always_comb begin
      if (i_io0_mode == IO0_MODE_ALERT) begin
         io0_oe_n_d = ~(i_fault | stall);
      end else begin
         io0_oe_n_d = i_io0_level;
      end
      io1_oe_n_d = ~((i_io1_mode == IO1_MODE_OUT) && !i_io1_level);
      unique case (i_io2_mode)
         IO2_MODE_GPIO: io2_oe_n_d = i_io2_level;
         IO2_MODE_CLKOUT: io2_oe_n_d = phase_q;
         default: io2_oe_n_d = 1'b1;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tach_prev_q <= '0;
         div_q <= 7'h00;
         phase_q <= 1'b0;
         ext_prev_q <= 1'b1;
         dac_q <= DAC_RESET;
         par_q <= 1'b0;
         rev_q <= 8'h00;
         override_q <= 1'b0;
         cap_done_q <= 1'b0;
         addr_q <= 7'h00;
         io0_oe_n_q <= 1'b1;
         io1_oe_n_q <= 1'b1;
         io2_oe_n_q <= 1'b1;
         in0_q <= 1'b1;
         in1_q <= 1'b1;
         in2_q <= 1'b1;
      end else begin
         tach_prev_q <= tach_prev_d;
         div_q <= div_d;
         phase_q <= phase_d;
         ext_prev_q <= ext_prev_d;
         dac_q <= dac_d;
         par_q <= par_d;
         rev_q <= rev_d;
         override_q <= override_d;
         cap_done_q <= cap_done_d;
         addr_q <= addr_d;
         io0_oe_n_q <= io0_oe_n_d;
         io1_oe_n_q <= io1_oe_n_d;
         io2_oe_n_q <= io2_oe_n_d;
         in0_q <= i_io_line_alert_capable;
         in1_q <= i_io_line_override_capable;
         in2_q <= i_io_line_clock_sync;
      end
   end

   // ------------------------------------------------------------
   // Outputs for the serial register file, byte-wide or narrower except the 16-bit tach periods
   // ------------------------------------------------------------
   assign o_slave_addr = addr_q;
   assign o_feedback_sense_code = dac_q;
   assign o_loop_period = per_q[0];
   assign o_monitor_period_a = per_q[1];
   assign o_monitor_period_b = per_q[2];
   assign o_monitor_period_c = per_q[3];
   assign o_rev_count = rev_q;
   assign o_full_speed = override_q;
   assign o_tach_stall = stall;
   assign o_io0_in = in0_q;
   assign o_io1_in = in1_q;
   assign o_io2_in = in2_q;
   assign o_io_line_alert_capable = 1'b0;
   assign o_io_line_alert_capable_oe_n = io0_oe_n_q;
   assign o_io_line_override_capable = 1'b0;
   assign o_io_line_override_capable_oe_n = io1_oe_n_q;
   assign o_io_line_clock_sync = 1'b0;
   assign o_io_line_clock_sync_oe_n = io2_oe_n_q;
endmodule : fsr_core
`default_nettype wire

// ---- fsr_checker.sv ----
// Assertions on the regulator core ports
`timescale 1ns/1ps
`default_nettype none
module fsr_checker
   import fsr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [1:0] i_addr_strap,
   input wire logic i_fault,
   input wire logic i_io0_mode,
   input wire logic i_io0_level,
   input wire logic [1:0] i_io1_mode,
   input wire logic i_io1_level,
   input wire logic i_io_line_override_capable,
   input wire logic [6:0] o_slave_addr,
   input wire logic [7:0] o_feedback_sense_code,
   input wire logic [7:0] o_rev_count,
   input wire logic o_full_speed,
   input wire logic o_io1_in,
   input wire logic o_io_line_alert_capable_oe_n,
   input wire logic o_io_line_override_capable_oe_n
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   wire logic [7:0] dac = o_feedback_sense_code;
   wire logic oe0 = o_io_line_alert_capable_oe_n;
   wire logic oe1 = o_io_line_override_capable_oe_n;
   wire logic [6:0] ax = (i_addr_strap == STRAP_GND) ? ADDR_GND : (i_addr_strap == STRAP_VCC) ?
      ADDR_VCC : (i_addr_strap == STRAP_OPEN) ? ADDR_OPEN : ADDR_RES;
   sequence s_override;
      i_io1_mode == IO1_MODE_FULL && !i_io_line_override_capable;
   endsequence
   sequence s_forced;
      o_full_speed ##1 (dac == DAC_MIN);
   endsequence
   a_addr_strap: assert property ($fell(i_reset) |=> o_slave_addr == $past(ax))
      else $error("address does not match strap");
   a_dac_step: assert property ($changed(dac) && !$past(i_reset) && !o_full_speed
      && !$past(o_full_speed) |-> 8'(dac - $past(dac)) inside {8'h01, 8'hff})
      else $error("drive code moved by more than one");
   a_rev_step: assert property ($changed(o_rev_count) && !$past(i_reset)
      |-> o_rev_count == 8'($past(o_rev_count) + 8'h01))
      else $error("revolution count skipped");
   a_full_force: assert property (s_override |=> s_forced)
      else $error("override did not force full speed");
   a_gpi_plain: assert property (i_io1_mode == IO1_MODE_GPI |=> !o_full_speed)
      else $error("full speed in general input mode");
   a_io1_drive: assert property (i_io1_mode == IO1_MODE_OUT |=> oe1 == $past(i_io1_level))
      else $error("line 1 output wrong");
   a_io1_read: assert property (1'b1 |=> o_io1_in == $past(i_io_line_override_capable))
      else $error("line 1 read wrong");
   a_alert_fault: assert property (i_io0_mode == IO0_MODE_ALERT && i_fault |=> !oe0)
      else $error("alert not pulled low");
   a_io0_drive: assert property (i_io0_mode == IO0_MODE_GPIO |=> oe0 == $past(i_io0_level))
      else $error("line 0 output wrong");
endmodule : fsr_checker
bind fsr_core fsr_checker chk_u (.*);
`default_nettype wire

// ---- fsr_fan_model.sv ----
// Fan model: tach pulses that slow down as the drive code rises
`timescale 1ns/1ps
`default_nettype none
module fsr_fan_model (
   input wire logic i_clk_sys,
   input wire logic i_run,
   input wire logic [7:0] i_code,
   output logic o_tach,
   output int o_pulses
);
   int cnt = 0;
   initial o_tach = 1'b0;
   initial o_pulses = 0;
   // Period grows with the drive code; each pulse is half a turn
   always @(negedge i_clk_sys) begin
      cnt <= (!i_run || cnt >= 1000 + 600 * i_code) ? 0 : cnt + 1;
      o_tach <= i_run && cnt < 12;
      if (i_run && cnt == 0) begin
         o_pulses <= o_pulses + 1;
      end
   end
endmodule : fsr_fan_model
`default_nettype wire

// ---- fsr_core_bench.sv ----
// Self-checking bench for the fan speed regulator core
`timescale 1ns/1ps
`default_nettype none
module fsr_core_bench
   import fsr_pkg::*;
;
   localparam int GL = 4;
   localparam int TK = 2 * OSC_HALF_CYCLES;
   logic i_clk_sys = 1'b0, i_reset = 1'b1, i_fault = 1'b0, i_io0_mode = 1'b0, i_io0_level = 1'b1;
   logic [1:0] i_addr_strap = 2'h0, i_io1_mode = 2'h1, i_io2_mode = 2'h0;
   logic [7:0] i_speed_target_value = 8'h00, o_feedback_sense_code, o_rev_count, exp_rev;
   logic [2:0] i_prescale_factor = 3'h0, mon = 3'h0;
   logic i_io1_level = 1'b1, i_io2_level = 1'b1, e0 = 1'b1, e1 = 1'b1, e2 = 1'b1;
   logic man = 1'b0, run = 1'b0, fan, i_loop_tach_input;
   logic i_monitor_tach_input_a, i_monitor_tach_input_b, i_monitor_tach_input_c;
   logic i_io_line_alert_capable, i_io_line_override_capable, i_io_line_clock_sync;
   logic [6:0] o_slave_addr;
   logic [6:0] addr_tab [4] = '{ADDR_GND, ADDR_VCC, ADDR_OPEN, ADDR_RES};
   logic [15:0] o_loop_period, o_monitor_period_a, o_monitor_period_b, o_monitor_period_c, per;
   logic o_full_speed, o_tach_stall, o_io0_in, o_io1_in, o_io2_in;
   logic o_io_line_alert_capable_oe_n, o_io_line_override_capable_oe_n, o_io_line_clock_sync_oe_n;
   logic [7:0] rev_q [$];
   int miscompares = 0, check_count = 0, seed = 19, pulse_n = 0, fan_pulses, tog, d;
   assign i_loop_tach_input = fan | man;
   assign {i_monitor_tach_input_a, i_monitor_tach_input_b, i_monitor_tach_input_c} = mon;
   assign i_io_line_alert_capable = e0 & o_io_line_alert_capable_oe_n;
   assign i_io_line_override_capable = e1 & o_io_line_override_capable_oe_n;
   assign i_io_line_clock_sync = e2 & o_io_line_clock_sync_oe_n;
   always #25 i_clk_sys = ~i_clk_sys;
   fsr_core #(.GLITCH_LEN(GL)) dut_u (.*, .o_io_line_alert_capable(),
      .o_io_line_override_capable(), .o_io_line_clock_sync());
   fsr_fan_model fan_u (.i_clk_sys(i_clk_sys), .i_run(run), .i_code(o_feedback_sense_code),
      .o_tach(fan), .o_pulses(fan_pulses));
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : cyc
   task automatic check(input logic [15:0] exp, input logic [15:0] act);
      check_count++;
      if (act !== exp) begin
         $display("unexpected at %0t: expected %h got %h", $time, exp, act);
         miscompares++;
      end
   endtask : check
   task automatic note_pulse();
      pulse_n++;
      if (pulse_n % 2 == 0) begin
         rev_q.push_back(8'(pulse_n / 2));
      end
   endtask : note_pulse
   task automatic pulse(input int w);
      man = 1'b1;
      cyc(w);
      man = 1'b0;
      cyc(60);
   endtask : pulse
   function automatic logic near(input logic [15:0] p);
      return p * TK <= tog + TK && p * TK + TK >= tog;
   endfunction : near
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // Revolution monitor
   // ----------------------------------------
   always @(fan_pulses) begin
      if (fan_pulses != 0) begin
         note_pulse();
      end
   end
   always @(o_rev_count) begin
      if (!i_reset) begin
         exp_rev = (rev_q.size() != 0) ? rev_q.pop_front() : 8'hxx;
         check({8'h00, exp_rev}, {8'h00, o_rev_count});
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      for (int s = 0; s < 4; s++) begin
         i_addr_strap = 2'(s);
         i_reset = 1'b1;
         cyc(2);
         i_reset = 1'b0;
         cyc(3);
         check({9'h0, addr_tab[s]}, {9'h0, o_slave_addr});
         check(16'(DAC_RESET), 16'(o_feedback_sense_code));
      end
      $display("test address done");
      repeat (3) pulse(GL - 1);
      check(16'h0000, o_loop_period);
      repeat (2) begin
         note_pulse();
         pulse(GL + 2);
      end
      $display("test glitch done");
      per = o_loop_period;
      repeat (4) begin
         tog = 400 + ($random(seed) & 255);
         repeat (3) begin
            mon = 3'h7;
            cyc(10);
            mon = 3'h0;
            cyc(tog - 10);
         end
         check(per, o_loop_period);
         check(16'h7, 16'({near(o_monitor_period_a), near(o_monitor_period_b),
            near(o_monitor_period_c)}));
      end
      $display("test monitor done");
      i_prescale_factor = 3'h2;
      run = 1'b1;
      repeat (3) @(posedge fan);
      cyc(GL + 4);
      check(16'h1, 16'(o_feedback_sense_code > 8'h00));
      repeat (12) @(posedge fan);
      cyc(GL + 4);
      d = int'(o_loop_period) - (((int'(i_speed_target_value) + 1) << TARGET_SHIFT) >> 2);
      check(16'h1, 16'(d <= 10 && d >= -10));
      i_io1_mode = IO1_MODE_FULL;
      e1 = 1'b0;
      cyc(3);
      check(16'h1, 16'(o_full_speed));
      check(16'(DAC_MIN), 16'(o_feedback_sense_code));
      i_io1_mode = IO1_MODE_GPI;
      cyc(2);
      check(16'h0, 16'({o_full_speed, o_io1_in}));
      e1 = 1'b1;
      repeat (3) @(posedge fan);
      cyc(GL + 4);
      check(16'h1, 16'(o_feedback_sense_code > 8'h00));
      i_prescale_factor = 3'h7;
      repeat (6) @(posedge fan);
      cyc(GL + 4);
      check(16'(DAC_MIN), 16'(o_feedback_sense_code));
      $display("test loop done");
      i_io0_mode = IO0_MODE_GPIO;
      i_io1_mode = IO1_MODE_OUT;
      i_io2_mode = IO2_MODE_GPIO;
      for (int v = 0; v < 2; v++) begin
         {i_io0_level, i_io1_level, i_io2_level} = {3{v[0]}};
         cyc(2);
         check(16'({3{v[0]}}), 16'({o_io_line_alert_capable_oe_n,
            o_io_line_override_capable_oe_n, o_io_line_clock_sync_oe_n}));
         check(16'({3{v[0]}}), 16'({o_io0_in, o_io1_in, o_io2_in}));
      end
      i_io0_mode = IO0_MODE_ALERT;
      i_fault = 1'b1;
      cyc(2);
      check(16'h0, 16'(o_io_line_alert_capable_oe_n));
      i_fault = 1'b0;
      cyc(2);
      check(16'h1, 16'({o_tach_stall, o_io_line_alert_capable_oe_n}));
      i_io2_mode = IO2_MODE_CLKIN;
      repeat (4) begin
         e2 = ~e2;
         cyc(2);
         check(16'(e2), 16'(o_io2_in));
      end
      mon = 3'h7;
      cyc(10);
      mon = 3'h0;
      repeat (6) begin
         e2 = ~e2;
         cyc(4);
      end
      mon = 3'h7;
      cyc(10);
      mon = 3'h0;
      check(16'h3, o_monitor_period_a);
      i_io2_mode = IO2_MODE_CLKOUT;
      e2 = 1'b1;
      cyc(4);
      tog = 0;
      repeat (2 * TK) begin
         cyc(1);
         tog += !o_io_line_clock_sync_oe_n;
      end
      check(16'h1, 16'(tog >= TK - 2 && tog <= TK + 2));
      $display("test lines done");
      print_verdict();
   end
   initial begin
      repeat (90000) @(posedge i_clk_sys);
      miscompares++;
      print_verdict();
   end
endmodule : fsr_core_bench
`default_nettype wire
